// ==== ftcr_regs.sv ====
// Serial-port register bank for the dual filter tuning and calibration control
`timescale 1ns/10ps
`default_nettype none

module ftcr_regs
	import ftcr_pkg::*;
(
	// Clock and reset
	input  wire logic         CLK_I,
	input  wire logic         RST_B_I,
	// Serial port pins
	input  wire logic         SCK_I,
	input  wire logic         SDI_I,
	input  wire logic         SEN_B_I,
	output var  logic         SDO_O,
	output var  logic         SDO_OE_O,
	// Calibration engine side
	input  wire ftcr_store_t  STORED_I,
	input  wire logic         CAL_DONE_I,
	input  wire logic [3:0]   CAL_FINE_I,
	input  wire logic [23:0]  CAL_COUNT_I,
	output var  logic         CAL_START_O,
	output var  logic         SELFTEST_START_O,
	output var  logic [14:0]  REF_PERIOD_O,
	output var  logic [23:0]  ADJ_COUNT_O,
	// Analog controls
	output var  logic         CAL_ENABLE_O,
	output var  logic         PATH_I_EN_O,
	output var  logic         PATH_Q_EN_O,
	output var  logic         REF_DOUBLER_O,
	output var  ftcr_set_t    SETTINGS_O,
	output var  logic [3:0]   FINE_CODE_O
);

	logic [2:0]  sck_s_r;
	logic [1:0]  sdi_s_r;
	logic [2:0]  sen_s_r;
	logic        sck_rise;
	logic        frame_start;
	logic        frame_end;
	logic [31:0] in_r;
	logic [31:0] out_r;
	logic [5:0]  cnt_r;
	logic        commit;
	logic        ours_r;
	logic [23:0] wdata;
	logic [4:0]  waddr;
	logic        cfg_rst;
	logic [4:0]  rd_addr_r;
	logic        soft_rst_r;
	logic [5:0]  enable_r;
	logic [9:0]  settings_r;
	logic [3:0]  manual_r;
	logic [14:0] period_r;
	logic [8:0]  correct_r;
	logic        st_mode_r;
	logic        busy_r;
	logic        strobe;
	logic        use_store;
	ftcr_set_t   set_nxt;
	logic [23:0] corr_ext;

	// Pins come from the host clock, so two stages before use
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			sck_s_r <= 3'h0;
			sdi_s_r <= 2'h0;
			sen_s_r <= 3'h7;
		end else begin
			sck_s_r <= {sck_s_r[1:0], SCK_I};
			sdi_s_r <= {sdi_s_r[0], SDI_I};
			sen_s_r <= {sen_s_r[1:0], SEN_B_I};
		end
	end

	assign sck_rise = sck_s_r[1] & ~sck_s_r[2] & ~sen_s_r[1];
	assign frame_start = ~sen_s_r[1] & sen_s_r[2];
	assign frame_end = sen_s_r[1] & ~sen_s_r[2];
	assign wdata = in_r[31:8];
	assign waddr = in_r[7:3];
	// Only a full frame carrying our chip code may change state
	assign commit = frame_end && (cnt_r == FRAME_CNT) && (in_r[2:0] == CHIP_ID);

	// Read-back decode for the frame that follows the address write
	function automatic logic [23:0] rd_word(input logic [4:0] a);
		logic [23:0] w;
		w = 24'h000000;
		unique case (a)
			OFS_READ_ADDR: w = {18'h00000, soft_rst_r, rd_addr_r};
			OFS_ENABLE: w = {18'h00000, enable_r};
			OFS_SETTINGS: w = {14'h0000, settings_r};
			OFS_MANUAL: w = {20'h00000, manual_r};
			OFS_PERIOD: w = {9'h000, period_r};
			OFS_CORRECT: w = {15'h0000, correct_r};
			OFS_CAL_STATUS: w = {19'h00000, busy_r, FINE_CODE_O};
			OFS_SELFTEST_EN: w = {23'h000000, st_mode_r};
			default: w = 24'h000000;
		endcase
		return w;
	endfunction

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			in_r <= 32'h00000000;
			cnt_r <= 6'h00;
		end else if (frame_start) begin
			in_r <= 32'h00000000;
			cnt_r <= 6'h00;
		end else if (sck_rise) begin
			in_r <= {in_r[30:0], sdi_s_r[1]};
			if (cnt_r != 6'h3F) begin
				cnt_r <= cnt_r + 6'h01;
			end
		end
	end

	// Output word is latched at frame start and moved on each rising edge
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			out_r <= 32'h00000000;
			SDO_O <= 1'b0;
		end else if (frame_start) begin
			out_r <= {rd_word(rd_addr_r), OFS_READ_ADDR, CHIP_ID};
		end else if (sck_rise) begin
			SDO_O <= out_r[31];
			out_r <= {out_r[30:0], 1'b0};
		end
	end

	// Output stays driven after an access to us until a foreign frame
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			ours_r <= 1'b0;
			SDO_OE_O <= 1'b0;
		end else begin
			if (frame_end && cnt_r == FRAME_CNT) begin
				ours_r <= (in_r[2:0] == CHIP_ID);
			end
			SDO_OE_O <= ours_r;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			rd_addr_r <= OFS_READ_ADDR;
			soft_rst_r <= 1'b0;
		end else if (commit && waddr == OFS_READ_ADDR) begin
			rd_addr_r <= wdata[4:0];
			soft_rst_r <= wdata[SOFT_RESET_BIT];
		end
	end

	// Soft reset holds the configuration at its defaults while set
	assign cfg_rst = !RST_B_I || soft_rst_r;

	always_ff @(posedge CLK_I) begin
		if (cfg_rst) begin
			enable_r <= ENABLE_RST;
			settings_r <= SETTINGS_RST;
			manual_r <= MANUAL_RST;
			period_r <= PERIOD_RST;
			correct_r <= CORRECT_RST;
			st_mode_r <= 1'b0;
		end else if (commit) begin
			unique case (waddr)
				OFS_ENABLE: enable_r <= wdata[5:0];
				OFS_SETTINGS: settings_r <= wdata[9:0];
				OFS_MANUAL: manual_r <= wdata[3:0];
				OFS_PERIOD: period_r <= wdata[14:0];
				OFS_CORRECT: correct_r <= wdata[8:0];
				OFS_SELFTEST_EN: st_mode_r <= wdata[0];
				default: ;
			endcase
		end
	end

	assign strobe = commit && (waddr == OFS_STROBE);

	always_ff @(posedge CLK_I) begin
		if (cfg_rst) begin
			CAL_START_O <= 1'b0;
			SELFTEST_START_O <= 1'b0;
		end else begin
			CAL_START_O <= strobe & enable_r[1];
			SELFTEST_START_O <= strobe & st_mode_r;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (cfg_rst) begin
			busy_r <= 1'b0;
		end else if (CAL_START_O) begin
			busy_r <= 1'b1;
		end else if (CAL_DONE_I) begin
			busy_r <= 1'b0;
		end
	end

	assign use_store = ~enable_r[0] & STORED_I.prg_flag;

	always_comb begin
		set_nxt = ftcr_set_t'(settings_r);
		if (use_store) begin
			set_nxt.coarse = {STORED_I.coarse_msb, STORED_I.coarse_lo};
			set_nxt.skip = STORED_I.skip;
			set_nxt.high_gain = STORED_I.high_gain;
			set_nxt.drv_bias = STORED_I.drv_bias;
			set_nxt.amp_bias = STORED_I.amp_bias;
		end
	end

	// Correction is in 1024 ps steps, so it is scaled by a shift
	assign corr_ext = {{5{correct_r[8]}}, correct_r, 10'h000};

	always_ff @(posedge CLK_I) begin
		if (cfg_rst) begin
			CAL_ENABLE_O <= 1'b0;
			PATH_I_EN_O <= 1'b1;
			PATH_Q_EN_O <= 1'b1;
			REF_DOUBLER_O <= 1'b0;
			SETTINGS_O <= ftcr_set_t'(SETTINGS_RST);
			FINE_CODE_O <= MANUAL_RST;
			REF_PERIOD_O <= PERIOD_RST;
			ADJ_COUNT_O <= 24'h000000;
		end else begin
			CAL_ENABLE_O <= enable_r[1];
			PATH_I_EN_O <= enable_r[2];
			PATH_Q_EN_O <= enable_r[3];
			REF_DOUBLER_O <= enable_r[5];
			SETTINGS_O <= set_nxt;
			if (enable_r[4]) begin
				FINE_CODE_O <= manual_r;
			end else if (use_store) begin
				FINE_CODE_O <= STORED_I.fine;
			end else begin
				FINE_CODE_O <= CAL_FINE_I;
			end
			REF_PERIOD_O <= period_r;
			ADJ_COUNT_O <= CAL_COUNT_I + corr_ext;
		end
	end

endmodule // ftcr_regs

`default_nettype wire

// ==== ftcr_pkg.sv ====
// Register map, reset values and carrier types for the filter tuning registers
package ftcr_pkg;
	// Serial frame layout
	localparam int FRAME_BITS = 32;
	localparam logic [5:0] FRAME_CNT = 6'h20;
	localparam logic [2:0] CHIP_ID = 3'h5;
	// Register offsets
	localparam logic [4:0] OFS_READ_ADDR = 5'h00;
	localparam logic [4:0] OFS_ENABLE = 5'h01;
	localparam logic [4:0] OFS_SETTINGS = 5'h02;
	localparam logic [4:0] OFS_MANUAL = 5'h03;
	localparam logic [4:0] OFS_STROBE = 5'h04;
	localparam logic [4:0] OFS_PERIOD = 5'h05;
	localparam logic [4:0] OFS_CORRECT = 5'h06;
	localparam logic [4:0] OFS_SPARE = 5'h07;
	localparam logic [4:0] OFS_CAL_STATUS = 5'h08;
	localparam logic [4:0] OFS_SELFTEST_EN = 5'h0E;
	// Field positions
	localparam int SOFT_RESET_BIT = 5;
	localparam int BUSY_BIT = 4;
	localparam int CORRECT_SHIFT = 10;
	// Reset values
	localparam logic [5:0] ENABLE_RST = 6'h0C;
	localparam logic [9:0] SETTINGS_RST = 10'h009;
	localparam logic [3:0] MANUAL_RST = 4'h0;
	localparam logic [14:0] PERIOD_RST = 15'h0000;
	localparam logic [8:0] CORRECT_RST = 9'h000;

	typedef struct packed {
		logic [3:0] coarse;
		logic       skip;
		logic       high_gain;
		logic [1:0] drv_bias;
		logic [1:0] amp_bias;
	} ftcr_set_t;

	// Nonvolatile word as it is read back
	typedef struct packed {
		logic       rsvd;
		logic       coarse_msb;
		logic       prg_flag;
		logic [1:0] drv_bias;
		logic [1:0] amp_bias;
		logic       skip;
		logic       high_gain;
		logic [2:0] coarse_lo;
		logic [3:0] fine;
	} ftcr_store_t;
endpackage : ftcr_pkg

// ==== ftcr_chk_sva.sv ====
// Port checker for the filter tuning register bank
`timescale 1ns/10ps
`default_nettype none
module ftcr_chk
	import ftcr_pkg::*;
(
	// Clock, reset and frame enable
	input wire logic        CLK_I,
	input wire logic        RST_B_I,
	input wire logic        SEN_B_I,
	// Watched count and outputs
	input wire logic [23:0] CAL_COUNT_I,
	input wire logic [23:0] ADJ_COUNT_O,
	input wire logic        CAL_START_O,
	input wire logic        SELFTEST_START_O,
	input wire logic        CAL_ENABLE_O,
	input wire logic        PATH_I_EN_O,
	input wire ftcr_set_t   SETTINGS_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	a_cal_one_shot: assert property (CAL_START_O |=> !CAL_START_O)
		else $error("cal start too long");
	a_st_one_shot: assert property (SELFTEST_START_O |=> !SELFTEST_START_O)
		else $error("self test start too long");
	a_cal_needs_en: assert property (CAL_START_O |-> CAL_ENABLE_O)
		else $error("cal start while disabled");
	a_start_after_frame: assert property ((CAL_START_O || SELFTEST_START_O) |-> SEN_B_I)
		else $error("start inside a frame");
	// Any correction is a whole number of 1024 ps steps within 9 signed bits
	a_adj_grid: assert property ($past(RST_B_I) |->
		((ADJ_COUNT_O - $past(CAL_COUNT_I) + 24'h040000) & 24'hF803FF) == 24'h000000)
		else $error("adjusted count off grid");
	a_reset_vals: assert property (!$past(RST_B_I) |->
		SETTINGS_O == 10'h009 && PATH_I_EN_O && !CAL_ENABLE_O)
		else $error("wrong value after reset");
	a_set_at_idle: assert property ($changed(SETTINGS_O) |-> SEN_B_I)
		else $error("settings moved inside a frame");
	a_path_at_idle: assert property ($changed({PATH_I_EN_O, CAL_ENABLE_O}) |-> SEN_B_I)
		else $error("enable moved inside a frame");
	c_cal: cover property (CAL_START_O);
	c_st: cover property (SELFTEST_START_O);
	c_set: cover property ($changed(SETTINGS_O));
endmodule // ftcr_chk
bind ftcr_regs ftcr_chk u_chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .SEN_B_I(SEN_B_I),
	.CAL_COUNT_I(CAL_COUNT_I), .ADJ_COUNT_O(ADJ_COUNT_O), .CAL_START_O(CAL_START_O),
	.SELFTEST_START_O(SELFTEST_START_O), .CAL_ENABLE_O(CAL_ENABLE_O),
	.PATH_I_EN_O(PATH_I_EN_O), .SETTINGS_O(SETTINGS_O));
`default_nettype wire

// ==== ftcr_host.sv ====
// Serial host model framing register traffic
`timescale 1ns/10ps
`default_nettype none
module ftcr_host (
	// Clock and serial pins
	input  wire logic CLK_I,
	input  wire logic SDO_I,
	output var  logic SCK_O,
	output var  logic SDI_O,
	output var  logic SEN_B_O
);
	initial {SCK_O, SDI_O, SEN_B_O} = 3'h1;
	// One frame MSB first; hp is the SCK half period in clocks
	task automatic xfer(input logic [31:0] w, input int hp, output logic [31:0] q);
		@(posedge CLK_I);
		#1 SEN_B_O = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			SDI_O = w[i];
			repeat (hp) @(posedge CLK_I);
			#1 SCK_O = 1'b1;
			repeat (hp) @(posedge CLK_I);
			#1 q[i] = SDO_I;
			SCK_O = 1'b0;
		end
		repeat (hp) @(posedge CLK_I);
		#1 SEN_B_O = 1'b1;
		// Idle data line flips so a stale bit never passes for data
		SDI_O = ~SDI_O;
		repeat (10) @(posedge CLK_I);
	endtask
endmodule // ftcr_host
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the filter tuning register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
	import ftcr_pkg::*;
	logic        clk = 1'b0, rst_b = 1'b0, cal_done = 1'b0;
	logic        sck, sdi, sen_b, sdo, sdo_oe, cal_start, st_start, cal_en, pth_i, pth_q, dbl;
	ftcr_store_t stored = 16'h197A;
	ftcr_set_t   settings;
	logic [3:0]  fine;
	logic [14:0] period;
	logic [23:0] cal_count = 24'h000000, adj;
	logic [31:0] r;
	int          n_fail = 0, n_compared = 0, n_cal = 0, n_st = 0, n_cyc = 0;
	logic [4:0]  ra [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h1F};
	logic [23:0] rr [8] = '{24'h00000C, 24'h000009, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0};
	logic [23:0] rx [8] = '{24'h3F, 24'h3FF, 24'hF, 24'h0, 24'h7FFF, 24'h1FF, 24'h0, 24'h0};
	always #5 clk = ~clk;
	ftcr_host host (.CLK_I(clk), .SDO_I(sdo_oe ? sdo : ~sdo), .SCK_O(sck), .SDI_O(sdi),
		.SEN_B_O(sen_b));
	ftcr_regs dut (.CLK_I(clk), .RST_B_I(rst_b), .SCK_I(sck), .SDI_I(sdi), .SEN_B_I(sen_b),
		.SDO_O(sdo), .SDO_OE_O(sdo_oe), .STORED_I(stored), .CAL_DONE_I(cal_done),
		.CAL_FINE_I(4'h6), .CAL_COUNT_I(cal_count), .CAL_START_O(cal_start),
		.SELFTEST_START_O(st_start), .REF_PERIOD_O(period), .ADJ_COUNT_O(adj),
		.CAL_ENABLE_O(cal_en), .PATH_I_EN_O(pth_i), .PATH_Q_EN_O(pth_q),
		.REF_DOUBLER_O(dbl), .SETTINGS_O(settings), .FINE_CODE_O(fine));
	task automatic complete_run;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [23:0] d);
		logic [31:0] q;
		host.xfer({d, a, CHIP_ID}, 5, q);
	endtask
	// Reads need an address frame, then a second frame that repeats it
	task automatic rd(input logic [4:0] a, input logic [23:0] e);
		logic [31:0] q;
		wr(OFS_READ_ADDR, {19'h0, a});
		host.xfer({19'h0, a, OFS_READ_ADDR, CHIP_ID}, 9, q);
		chk(q, {e, 5'h00, CHIP_ID});
	endtask
	always @(posedge clk) begin
		n_cyc <= n_cyc + 1;
		if (cal_start === 1'b1) n_cal <= n_cal + 1;
		if (st_start === 1'b1) n_st <= n_st + 1;
		if (n_cyc == 80000) begin
			n_fail++;
			complete_run();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 8; i++) rd(ra[i], rr[i]);
		for (int i = 0; i < 8; i++) begin
			wr(ra[i], 24'hFFFFFF);
			rd(ra[i], rx[i]);
		end
		chk({pth_i, pth_q, cal_en, dbl}, 4'hF);
		chk(period, 15'h7FFF);
		chk(fine, 4'hF);
		chk(n_cal, 1);
		rd(OFS_CAL_STATUS, 24'h00001F);
		@(posedge clk);
		#1 cal_done = 1'b1;
		cal_count = 24'h001000;
		@(posedge clk);
		#1 cal_done = 1'b0;
		rd(OFS_CAL_STATUS, 24'h00000F);
		chk(adj, 24'h000C00);
		wr(OFS_CORRECT, 24'h0000FF);
		chk(adj, 24'h040C00);
		// Self-test mode goes in before the strobe
		wr(OFS_SELFTEST_EN, 24'h000001);
		wr(OFS_STROBE, 24'h123456);
		chk(n_st, 1);
		chk(n_cal, 2);
		for (int c = 0; c < 9; c++) begin
			wr(OFS_SETTINGS, {14'h0, c[3:0], 6'h16});
			chk(settings, {c[3:0], 6'h16});
		end
		wr(OFS_ENABLE, 24'h00000C);
		chk({settings, fine}, {10'h216, 4'h6});
		#1 stored = 16'h397A;
		repeat (3) @(posedge clk);
		#1 chk({settings, fine}, {10'h1EC, 4'hA});
		host.xfer({24'h0, OFS_SETTINGS, 3'h2}, 5, r);
		chk(sdo_oe, 1'b0);
		// Soft reset returns config to defaults until it is written clear again
		wr(OFS_READ_ADDR, 24'h000020);
		chk({settings, pth_i, pth_q, cal_en}, {10'h009, 3'h6});
		chk(period, 15'h0000);
		wr(OFS_READ_ADDR, 24'h000000);
		chk({settings, fine}, {10'h1EC, 4'hA});
		complete_run();
	end
endmodule // tb
`default_nettype wire
